// *** cseq_params.svh ***
// Constants of the core sequencer: register offsets, reset values,
// program size codes, reset vectors and special data addresses.
// Assumes inclusion by bare name from the core, the checker and the bench.
`ifndef CSEQ_PARAMS_SVH
`define CSEQ_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses on the AXI4-Lite bus)
`define CSEQ_OFS_CTRL      4'h0
`define CSEQ_OFS_STATE     4'h4
`define CSEQ_OFS_POINTER   4'h8
`define CSEQ_OFS_INSTR     4'hC

// ==========================================================
// Control register fields
`define CSEQ_CTRL_SIZE_LSB 0
`define CSEQ_CTRL_BANK_BIT 2
`define CSEQ_CTRL_RST_BIT  3

// ==========================================================
// Program size codes and reset vectors
`define CSEQ_SIZE_512      2'h0
`define CSEQ_SIZE_1K       2'h1
`define CSEQ_SIZE_2K       2'h2
`define CSEQ_VEC_512       11'h1FF
`define CSEQ_VEC_1K        11'h3FF
`define CSEQ_VEC_2K        11'h7FF

// ==========================================================
// Reset values and codes
`define CSEQ_RST_SIZE      2'h0
`define CSEQ_RST_BANK      1'h0
`define CSEQ_RST_POINTER   7'h00
`define CSEQ_NOP_WORD      12'h000
`define CSEQ_ZERO_BYTE     8'h00

// ==========================================================
// Special data register addresses
`define CSEQ_ADDR_PORT     5'h00
`define CSEQ_ADDR_POINTER  5'h04

// ==========================================================
// AXI responses
`define CSEQ_RESP_OKAY     2'h0
`define CSEQ_RESP_SLVERR   2'h2

`endif

// *** cseq_pkg.sv ***
// Types shared by the core sequencer.
// Assumes cseq_params.svh sits in the same folder.
package cseq_pkg;

  // ==========================================================
  // Phase of the instruction cycle, one-hot
  typedef enum logic [3:0] {
    CSEQ_PH_ONE   = 4'b0001,
    CSEQ_PH_TWO   = 4'b0010,
    CSEQ_PH_THREE = 4'b0100,
    CSEQ_PH_FOUR  = 4'b1000
  } cseq_phase_t;

  // ==========================================================
  // Configuration held in the control register
  typedef struct packed {
    logic       banked;
    logic [1:0] size;
  } cseq_cfg_t;

  // ==========================================================
  // Request from the executing logic for the current instruction
  typedef struct packed {
    logic        jump;
    logic [8:0]  target;
    logic [4:0]  file_addr;
    logic        write;
    logic [7:0]  result;
  } cseq_exec_t;

endpackage

// *** cseq_core.sv ***
// Core sequencer: phase divider, two-stage fetch/execute pipeline,
// program counter sizing and wrap, reset vector, indirect data port.
// Assumes program memory answers combinationally within one phase,
// and the data register file is external for all addresses but 0/4.
// Overview of operation
// - Divide the input clock by four into four non-overlapping phases.
// - Program counter advances in phase one; fetched word captured end phase four.
// - Fetch and execute overlap; each stage takes one instruction cycle.
// - Program counter changes take two cycles; the prefetched word is discarded.
// - Instruction register holds the word from phase one; execute in phases 2-4.
// - Operand read in phase two; result written in phase four.
// - Program counter width selectable as 9, 10 or 11 bits.
// - Addresses beyond the implemented memory wrap modulo its size.
// - Reset vector is the highest address: 1FFh, 3FFh or 7FFh.
// - A no-operation at the reset vector wraps execution to address zero.
// - Above 512 words, status page bits select the program page.
// - Above 32 registers, the indirect pointer chooses the data bank.
// - The indirect data port has no storage; it redirects via the pointer.
// - Reading the port with the pointer at zero returns 00h.
// - Writing the port with the pointer at zero stores nothing.
// - Pointer is 5 bits unbanked and 7 bits banked.
// - Low five pointer bits select data address 00h to 1Fh.
// - Unbanked, pointer bits six and five read as ones.
// - Banked, pointer bits six and five select bank 0 to 3.
`timescale 1ns/1ps
`include "cseq_params.svh"

module cseq_core
  import cseq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Phase clocks
  output cseq_phase_t      phase,
  // Program memory
  output logic [10:0]      prog_addr,
  input  wire logic [11:0] prog_data,
  // Executing logic
  output logic [11:0]      instr_word,
  output logic             instr_valid,
  input  wire cseq_exec_t  exec_req,
  input  wire logic [1:0]  status_page,
  output logic [7:0]       operand,
  // Data register file
  output logic [6:0]       data_addr,
  output logic             data_rd_en,
  input  wire logic [7:0]  data_rd_data,
  output logic             data_wr_en,
  output logic [7:0]       data_wr_data
);

  // ==========================================================
  // Functions
  // Mask of implemented program address bits for a size code
  function automatic logic [10:0] size_mask(input logic [1:0] sz);
    case (sz)
      `CSEQ_SIZE_512: size_mask = 11'h1FF;
      `CSEQ_SIZE_1K:  size_mask = 11'h3FF;
      default:        size_mask = 11'h7FF;
    endcase
  endfunction

  // Reset vector for a size code
  function automatic logic [10:0] size_vector(input logic [1:0] sz);
    case (sz)
      `CSEQ_SIZE_512: size_vector = `CSEQ_VEC_512;
      `CSEQ_SIZE_1K:  size_vector = `CSEQ_VEC_1K;
      default:        size_vector = `CSEQ_VEC_2K;
    endcase
  endfunction

  // ==========================================================
  // State
  cseq_phase_t  next_phase;
  cseq_cfg_t    cfg;
  logic [10:0]  pc;
  logic [7:0]   pointer;
  logic [6:0]   ptr_bits;
  logic         restart;
  logic         aw_held;
  logic         w_held;
  logic [3:0]   aw_addr;
  logic [7:0]   w_byte;
  logic         w_lane;

  // ==========================================================
  // Phase divider
  // Advance one phase per input clock
  always_comb begin
    case (phase)
      CSEQ_PH_ONE:   next_phase = CSEQ_PH_TWO;
      CSEQ_PH_TWO:   next_phase = CSEQ_PH_THREE;
      CSEQ_PH_THREE: next_phase = CSEQ_PH_FOUR;
      CSEQ_PH_FOUR:  next_phase = CSEQ_PH_ONE;
      default:       next_phase = CSEQ_PH_ONE;
    endcase
  end

  wire ph_one   = (phase == CSEQ_PH_ONE);
  wire ph_two   = (phase == CSEQ_PH_TWO);
  wire ph_four  = (phase == CSEQ_PH_FOUR);

  // Restart realigns to phase one
  always_ff @(posedge aclk) begin
    if (!aresetn || restart)
      phase <= CSEQ_PH_ONE;
    else
      phase <= next_phase;
  end

  // ==========================================================
  // Program counter and fetch
  wire [10:0] mask       = size_mask(cfg.size);
  wire [10:0] vector     = size_vector(cfg.size);
  wire [10:0] pc_inc     = (prog_addr + 11'h001) & mask;
  wire [10:0] jump_addr  = {status_page, exec_req.target} & mask;
  wire        take_jump  = instr_valid && exec_req.jump;
  wire [10:0] next_fetch = take_jump ? jump_addr : pc;

  // Fetch address latched at cycle start; jumps redirect it
  always_ff @(posedge aclk) begin
    if (!aresetn)
      prog_addr <= `CSEQ_VEC_512;
    else if (restart)
      prog_addr <= vector;
    else if (ph_four)
      prog_addr <= next_fetch;
  end

  // Counter steps past the fetch address during phase one
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pc <= `CSEQ_VEC_512;
    else if (restart)
      pc <= vector;
    else if (ph_one)
      pc <= pc_inc;
  end

  // Instruction register loads at the phase four / phase one edge
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      instr_word  <= `CSEQ_NOP_WORD;
      instr_valid <= 1'b0;
    end else if (ph_four) begin
      instr_word  <= take_jump ? `CSEQ_NOP_WORD : prog_data;
      instr_valid <= !take_jump;
    end
  end

  // ==========================================================
  // Indirect addressing
  // Pointer view: unbanked keeps five bits, bits 7:5 read as ones
  assign ptr_bits = cfg.banked ? pointer[6:0]
                               : {2'b11, pointer[4:0]};
  wire [7:0] ptr_read = {1'b1, ptr_bits};

  wire       via_port  = (exec_req.file_addr == `CSEQ_ADDR_PORT);
  wire [4:0] eff_addr  = via_port ? pointer[4:0] : exec_req.file_addr;
  wire       self_ref  = (eff_addr == `CSEQ_ADDR_PORT);
  wire       is_ptr    = (eff_addr == `CSEQ_ADDR_POINTER);
  wire [1:0] bank      = cfg.banked ? pointer[6:5] : 2'b00;

  // Data register file addressing
  assign data_addr    = {bank, eff_addr};
  assign data_rd_en   = instr_valid && ph_two && !self_ref && !is_ptr;
  assign data_wr_en   = instr_valid && ph_four && exec_req.write
                        && !self_ref && !is_ptr;
  assign data_wr_data = exec_req.result;

  // Operand captured at the end of phase two
  always_ff @(posedge aclk) begin
    if (!aresetn)
      operand <= `CSEQ_ZERO_BYTE;
    else if (instr_valid && ph_two) begin
      if (self_ref)
        operand <= `CSEQ_ZERO_BYTE;
      else if (is_ptr)
        operand <= ptr_read;
      else
        operand <= data_rd_data;
    end
  end

  // Pointer writes: executing instruction in phase four, else bus
  wire core_ptr_wr = instr_valid && ph_four && exec_req.write && is_ptr;
  wire bus_wr      = aw_held && w_held && !s_axi_bvalid;
  wire bus_ptr_wr  = bus_wr && w_lane && (aw_addr == `CSEQ_OFS_POINTER);
  wire bus_ctl_wr  = bus_wr && w_lane && (aw_addr == `CSEQ_OFS_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      pointer <= {1'b0, `CSEQ_RST_POINTER};
    else if (core_ptr_wr)
      pointer <= exec_req.result;
    else if (bus_ptr_wr)
      pointer <= w_byte;
  end

  // ==========================================================
  // Configuration and restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.size   <= `CSEQ_RST_SIZE;
      cfg.banked <= `CSEQ_RST_BANK;
      restart    <= 1'b0;
    end else begin
      restart <= bus_ctl_wr && w_byte[`CSEQ_CTRL_RST_BIT];
      if (bus_ctl_wr) begin
        cfg.size   <= w_byte[`CSEQ_CTRL_SIZE_LSB +: 2];
        cfg.banked <= w_byte[`CSEQ_CTRL_BANK_BIT];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write channel: address and data in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[3:2], 2'b00};
    end else if (bus_wr) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end else if (bus_wr) begin
      w_held <= 1'b0;
    end
  end

  // Write response one cycle after both halves are held
  wire wr_mapped = (aw_addr == `CSEQ_OFS_CTRL) || (aw_addr == `CSEQ_OFS_POINTER);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CSEQ_RESP_OKAY;
    end else if (bus_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `CSEQ_RESP_OKAY : `CSEQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  wire [3:0] rd_ofs = {s_axi_araddr[3:2], 2'b00};
  logic [31:0] rd_word;
  logic        rd_ok;

  // Read data selection
  always_comb begin
    rd_ok   = 1'b1;
    case (rd_ofs)
      `CSEQ_OFS_CTRL:    rd_word = {29'h0, cfg.banked, cfg.size};
      `CSEQ_OFS_STATE:   rd_word = {17'h0, phase, pc};
      `CSEQ_OFS_POINTER: rd_word = {24'h0, ptr_read};
      `CSEQ_OFS_INSTR:   rd_word = {19'h0, instr_valid, instr_word};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CSEQ_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `CSEQ_RESP_OKAY : `CSEQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cseq_core

// *** cseq_chk.sv ***
// Checker: phase order, fetch, flush and data timing of cseq_core.
// Sees only top ports; bound to every cseq_core at the foot.
`timescale 1ns/1ps
`include "cseq_params.svh"
module cseq_chk
  import cseq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire cseq_phase_t phase,
  input wire logic [10:0] prog_addr,
  input wire logic [11:0] prog_data,
  input wire logic [11:0] instr_word,
  input wire logic        instr_valid,
  input wire cseq_exec_t  exec_req,
  input wire logic [6:0]  data_addr,
  input wire logic        data_rd_en,
  input wire logic        data_wr_en,
  input wire logic [7:0]  data_wr_data
);
  // ====================================
  // Helpers: a bus write may restart the pipe, so hold off around it
  // Hold off one edge after reset ends too, while the pipe is still parked
  logic [2:0] wq;
  logic       quiet, p4, jmp, up;
  assign quiet = s_axi_bvalid | (|wq) | !up;
  assign p4    = phase == CSEQ_PH_FOUR;
  assign jmp   = p4 && instr_valid && exec_req.jump;
  always_ff @(posedge aclk) begin
    wq <= aresetn ? {wq[1:0], s_axi_bvalid} : 3'h0;
    up <= aresetn;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || quiet);
  // ====================================
  // Properties
  sequence s_rest;
    phase == CSEQ_PH_TWO ##1 phase == CSEQ_PH_THREE ##1 p4;
  endsequence
  sequence s_load;
    instr_valid && instr_word == $past(prog_data) ##1 $stable(instr_word) [*3];
  endsequence
  a_phase_order: assert property (phase == CSEQ_PH_ONE |=> s_rest)
    else $error("phase sequence broken");
  a_phase_hot: assert property ($onehot(phase))
    else $error("phase not one-hot");
  a_addr_hold: assert property (!p4 |=> $stable(prog_addr))
    else $error("fetch address moved mid-cycle");
  a_seq_step: assert property (
    p4 && !jmp |=> prog_addr[8:0] == $past(prog_addr[8:0]) + 9'h001)
    else $error("fetch address did not step");
  a_instr_load: assert property (p4 && !jmp |=> s_load)
    else $error("instruction word not latched");
  a_jump_go: assert property (
    jmp |=> !instr_valid && prog_addr[8:0] == $past(exec_req.target))
    else $error("jump target not fetched");
  a_flush_slot: assert property (jmp |=> instr_word == `CSEQ_NOP_WORD ##4 instr_valid)
    else $error("flushed slot wrong");
  a_read_phase: assert property (
    data_rd_en |-> phase == CSEQ_PH_TWO && data_addr[4:0] != `CSEQ_ADDR_PORT)
    else $error("operand read out of place");
  a_write_phase: assert property (
    data_wr_en |-> p4 && data_wr_data == exec_req.result && data_addr[4:0] != 5'h00)
    else $error("result write out of place");
  a_direct_addr: assert property (
    data_wr_en && exec_req.file_addr != 5'h00 |-> data_addr[4:0] == exec_req.file_addr)
    else $error("direct address not passed");
endmodule // cseq_chk

bind cseq_core cseq_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .phase, .prog_addr, .prog_data,
  .instr_word, .instr_valid, .exec_req, .data_addr, .data_rd_en, .data_wr_en, .data_wr_data);

// *** cseq_mem.sv ***
// Far side: program memory and data register file.
// Assumes the bench preloads both arrays before reset ends.
`timescale 1ns/1ps
module cseq_mem (
  input wire logic        aclk,
  input wire logic [10:0] prog_addr,
  output logic     [11:0] prog_data,
  input wire logic [6:0]  data_addr,
  input wire logic        data_rd_en,
  output logic     [7:0]  data_rd_data,
  input wire logic        data_wr_en,
  input wire logic [7:0]  data_wr_data
);
  logic [11:0] prog [2048];
  logic [7:0]  regs [128];
  // ====================================
  // Reads; an idle read bus shows the inverse so stale data never helps
  assign prog_data    = prog[prog_addr];
  assign data_rd_data = data_rd_en ? regs[data_addr] : ~regs[data_addr];
  // Write lands on the edge that ends the write strobe
  // Plain always: the bench also preloads this array by reference
  always @(posedge aclk) begin
    if (data_wr_en) regs[data_addr] <= data_wr_data;
  end
endmodule // cseq_mem

// *** tb.sv ***
// Bench: reset, sizes, pointer, indirect port, jumps of cseq_core.
// Drives AXI4-Lite and the execute request; cseq_mem is the far side.
`timescale 1ns/1ps
`include "cseq_params.svh"
module tb
  import cseq_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, instr_valid, data_rd_en, data_wr_en;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, status_page;
  logic [10:0] prog_addr;
  logic [11:0] prog_data, instr_word;
  logic [7:0]  operand, data_rd_data, data_wr_data;
  logic [6:0]  data_addr;
  cseq_phase_t phase;
  cseq_exec_t  exec_req;
  int          n_fail = 0, n_compared = 0, cyc = 0;

  cseq_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .phase, .prog_addr, .prog_data, .instr_word, .instr_valid, .exec_req,
    .status_page, .operand, .data_addr, .data_rd_en, .data_rd_data, .data_wr_en, .data_wr_data);
  cseq_mem u_mem (.aclk, .prog_addr, .prog_data, .data_addr, .data_rd_en, .data_rd_data,
    .data_wr_en, .data_wr_data);

  // ====================================
  // Clock and cycle ceiling
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      end_sim;
    end
  end

  // ====================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [10:0] vec(input int m);
    return m == 0 ? `CSEQ_VEC_512 : m == 1 ? `CSEQ_VEC_1K : `CSEQ_VEC_2K;
  endfunction
  // Bus write: address and data offered together, each dropped when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] v,
                     input logic [1:0] er = `CSEQ_RESP_OKAY);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk(s_axi_rresp, `CSEQ_RESP_OKAY);
  endtask
  // One instruction: request held from phase two to the edge ending phase four
  task automatic run(input cseq_exec_t r, input logic [1:0] pg);
    do begin @(posedge aclk); #1; end while (!(phase == CSEQ_PH_ONE && instr_valid));
    @(posedge aclk);
    exec_req <= r;
    status_page <= pg;
    repeat (3) @(posedge aclk);
    exec_req <= '0;
    #1;
  endtask

  // ====================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [6:0]  p;
    logic [1:0]  pg;
    cseq_exec_t  r;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, status_page} = '0;
    s_axi_wstrb = 4'hF;
    exec_req = '0;
    void'($urandom(32'h3924));
    for (int i = 0; i < 2048; i++) u_mem.prog[i] = 12'($urandom);
    for (int i = 0; i < 128; i++) u_mem.regs[i] = 8'($urandom);
    for (int m = 0; m < 3; m++) u_mem.prog[vec(m)] = `CSEQ_NOP_WORD;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(prog_addr, `CSEQ_VEC_512);
    repeat (4) @(posedge aclk);
    #1;
    chk(prog_addr, 11'h000);
    chk({instr_valid, instr_word}, 13'h1000);
    axr(`CSEQ_OFS_INSTR, d);
    chk(d, 32'h0000_1000);
    axr(`CSEQ_OFS_POINTER, d);
    chk(d, 32'h0000_00E0);
    for (int m = 0; m < 3; m++) begin
      axw(`CSEQ_OFS_CTRL, {28'h0, 1'b1, (m == 2), 2'(m)});
      do begin @(posedge aclk); #1; end while (prog_addr !== vec(m));
      do begin @(posedge aclk); #1; end while (prog_addr === vec(m));
      chk(prog_addr, 11'h000);
      axr(`CSEQ_OFS_CTRL, d);
      chk(d, {29'h0, (m == 2), 2'(m)});
      repeat (4) begin
        p = {2'($urandom), 5'(8 + $urandom % 24)};
        axw(`CSEQ_OFS_POINTER, {25'h0, p});
        axr(`CSEQ_OFS_POINTER, d);
        chk(d, {24'h0, 1'b1, (m == 2 ? p[6:5] : 2'b11), p[4:0]});
        d = $urandom;
        run('{1'b0, 9'h000, p[4:0], 1'b1, d[7:0]}, 2'b00);
        run('{1'b0, 9'h000, `CSEQ_ADDR_PORT, 1'b0, 8'h00}, 2'b00);
        chk(operand, d[7:0]);
        if (m == 2) chk(u_mem.regs[p], d[7:0]);
        pg = $urandom;
        r = '{1'b1, 9'($urandom), 5'h00, 1'b0, 8'h00};
        run(r, pg);
        chk(prog_addr, {pg, r.target} & vec(m));
        chk(instr_valid, 1'b0);
      end
      axw(`CSEQ_OFS_POINTER, 32'h0000_0000);
      run('{1'b0, 9'h000, `CSEQ_ADDR_PORT, 1'b1, 8'hA5}, 2'b00);
      run('{1'b0, 9'h000, `CSEQ_ADDR_PORT, 1'b0, 8'h00}, 2'b00);
      chk(operand, `CSEQ_ZERO_BYTE);
    end
    // Unmapped write is refused and leaves the configuration alone
    axw(`CSEQ_OFS_STATE, 32'h0000_0008, `CSEQ_RESP_SLVERR);
    axr(`CSEQ_OFS_CTRL, d);
    chk(d, 32'h0000_0006);
    // Second reset in mid-run: vector and unbanked pointer view return
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(prog_addr, `CSEQ_VEC_512);
    axr(`CSEQ_OFS_POINTER, d);
    chk(d, 32'h0000_00E0);
    end_sim;
  end
endmodule // tb
